/* File: rtl/bps_core.v */
`timescale 1ns/1ps
`include "bps_defs.vh"

module bps_core #(
	parameter [19:0] LOAD_PERIOD_CYC = `BPS_LOAD_PERIOD_CYC
) (
	input wire i_clk_sys,
	input wire i_reset_n,
	input wire [3:0] i_addr,
	input wire [7:0] i_wr_data,
	input wire i_wr_en,
	input wire i_rd_en,
	output reg [7:0] o_rd_data,
	input wire i_tx_data_clk,
	input wire i_rx_data_clk,
	input wire i_rx_data,
	output reg o_tx_data,
	output reg o_tx_load_strobe,
	output wire o_tx_parallel_bit,
	output reg o_cpu_test_input_lock,
	output reg o_cpu_counter_input_errors,
	output reg o_dropout
);

	localparam [1:0] TX_START = 2'd0;
	localparam [1:0] TX_DATA = 2'd1;
	localparam [1:0] TX_STOP = 2'd2;
	localparam [1:0] RX_IDLE = 2'd0;
	localparam [1:0] RX_DATA = 2'd1;
	localparam [1:0] RX_STOP = 2'd2;
	localparam [19:0] LOAD_PULSE_CYC = `BPS_LOAD_PULSE_CYC;

	// ----------------------------------------------------------------
	// Pin synchronisers and clock edge detection
	// ----------------------------------------------------------------
	reg [2:0] txc_q;
	reg [2:0] rxc_q;
	reg [1:0] rxd_q;
	wire tx_edge;
	wire rx_clk_edge;

	always @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			txc_q <= 3'h0;
			rxc_q <= 3'h0;
			rxd_q <= 2'h0;
		end else begin
			txc_q <= {txc_q[1:0], i_tx_data_clk};
			rxc_q <= {rxc_q[1:0], i_rx_data_clk};
			rxd_q <= {rxd_q[0], i_rx_data};
		end
	end

	assign tx_edge = txc_q[1] & ~txc_q[2];
	assign rx_clk_edge = rxc_q[1] & ~rxc_q[2];

	// ----------------------------------------------------------------
	// Software registers
	// ----------------------------------------------------------------
	reg [7:0] ctrl_q;
	reg [3:0] bits_sel_q;
	reg [7:0] tx_word_q;
	reg [1:0] pat_prev_q;
	wire [1:0] pat_sel;
	wire fixed_mode;
	wire framed;
	wire loopback;
	wire cmd_wr;
	wire clr_sync;
	wire clr_event;
	wire clr_count;
	wire pat_change;

	assign pat_sel = ctrl_q[`BPS_CTRL_PAT_HI:`BPS_CTRL_PAT_LO];
	assign fixed_mode = ctrl_q[`BPS_CTRL_FIXED];
	assign framed = ctrl_q[`BPS_CTRL_FRAMED];
	assign loopback = ctrl_q[`BPS_CTRL_LOOP];
	assign cmd_wr = i_wr_en && (i_addr == `BPS_REG_CMD);
	assign pat_change = (pat_sel != pat_prev_q);
	assign clr_sync = (cmd_wr && i_wr_data[`BPS_CMD_CLR_SYNC]) || pat_change;
	assign clr_event = cmd_wr && i_wr_data[`BPS_CMD_CLR_EVENT];
	assign clr_count = cmd_wr && i_wr_data[`BPS_CMD_CLR_COUNT];

	always @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			ctrl_q <= `BPS_CTRL_RST;
			bits_sel_q <= `BPS_BITS_RST;
			tx_word_q <= `BPS_TXWORD_RST;
			pat_prev_q <= `BPS_PAT_2047;
		end else begin
			pat_prev_q <= pat_sel;
			if (i_wr_en && i_addr == `BPS_REG_CTRL) begin
				ctrl_q <= i_wr_data;
			end
			if (i_wr_en && i_addr == `BPS_REG_BITS) begin
				bits_sel_q <= i_wr_data[3:0];
			end
			if (i_wr_en && i_addr == `BPS_REG_TXWORD) begin
				tx_word_q <= i_wr_data;
			end
		end
	end

	// Codes outside the table fall back to eight bits so a bad code never stalls framing.
	reg [2:0] nbits_last;
	always @* begin
		case (bits_sel_q)
			`BPS_SEL_5BITS: nbits_last = 3'd4;
			`BPS_SEL_6BITS: nbits_last = 3'd5;
			`BPS_SEL_7BITS: nbits_last = 3'd6;
			`BPS_SEL_8BITS: nbits_last = 3'd7;
			default: nbits_last = 3'd7;
		endcase
	end

	// ----------------------------------------------------------------
	// Fixed-word parallel load strobe
	// ----------------------------------------------------------------
	reg [19:0] load_cnt_q;
	always @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			load_cnt_q <= 20'h0;
			o_tx_load_strobe <= 1'b0;
		end else if (!fixed_mode) begin
			load_cnt_q <= 20'h0;
			o_tx_load_strobe <= 1'b0;
		end else begin
			load_cnt_q <= (load_cnt_q == LOAD_PERIOD_CYC - 20'd1) ? 20'h0 : load_cnt_q + 20'd1;
			o_tx_load_strobe <= (load_cnt_q < LOAD_PULSE_CYC);
		end
	end

	// ----------------------------------------------------------------
	// Transmitter
	// ----------------------------------------------------------------
	reg [1:0] tx_fr_q;
	reg [2:0] tx_bit_cnt_q;
	reg [3:0] errgen_cnt_q;
	reg [7:0] tx_shift_q;
	wire tx_fb;
	wire tx_data_strobe;
	wire tx_bit;

	assign tx_data_strobe = tx_edge && (!framed || tx_fr_q == TX_DATA);
	assign tx_bit = (fixed_mode ? tx_shift_q[0] : tx_fb) ^
		(ctrl_q[`BPS_CTRL_ERRGEN] && errgen_cnt_q == `BPS_ERRGEN_LAST);
	assign o_tx_parallel_bit = tx_shift_q[0];

	bps_prbs u_tx_prbs (
		.i_clk_sys(i_clk_sys),
		.i_reset_n(i_reset_n),
		.i_step(tx_data_strobe && !fixed_mode),
		.i_load(1'b0),
		.i_load_val(`BPS_SEED),
		.i_pat(pat_sel),
		.o_state_q(),
		.o_fb(tx_fb)
	);

	always @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			tx_fr_q <= TX_DATA;
			tx_bit_cnt_q <= 3'd0;
			errgen_cnt_q <= 4'h0;
			tx_shift_q <= 8'hff;
			o_tx_data <= 1'b1;
		end else begin
			if (fixed_mode && load_cnt_q == 20'h0) begin
				tx_shift_q <= tx_word_q;
			end else if (tx_data_strobe && fixed_mode) begin
				tx_shift_q <= {1'b1, tx_shift_q[7:1]};
			end
			if (!ctrl_q[`BPS_CTRL_ERRGEN]) begin
				errgen_cnt_q <= 4'h0;
			end else if (tx_data_strobe) begin
				errgen_cnt_q <= errgen_cnt_q + 4'h1;
			end
			if (!framed) begin
				tx_fr_q <= TX_DATA;
				tx_bit_cnt_q <= 3'd0;
				if (tx_edge) begin
					o_tx_data <= tx_bit;
				end
			end else if (tx_edge) begin
				case (tx_fr_q)
					TX_START: begin
						o_tx_data <= 1'b0;
						tx_fr_q <= TX_DATA;
						tx_bit_cnt_q <= 3'd0;
					end
					TX_DATA: begin
						o_tx_data <= tx_bit;
						tx_bit_cnt_q <= tx_bit_cnt_q + 3'd1;
						if (tx_bit_cnt_q == nbits_last) begin
							tx_fr_q <= TX_STOP;
						end
					end
					TX_STOP: begin
						o_tx_data <= 1'b1;
						tx_fr_q <= TX_START;
					end
					default: tx_fr_q <= TX_START;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// Receiver framing and forward register
	// ----------------------------------------------------------------
	reg [1:0] rx_fr_q;
	reg [2:0] rx_bit_cnt_q;
	reg [10:0] rx_sync_forward_register;
	wire rx_edge;
	wire rx_bit;
	wire rx_strobe;
	reg rx_pred;

	// In loopback the receiver samples on the transmit edge, so it sees the previous bit.
	assign rx_edge = loopback ? tx_edge : rx_clk_edge;
	assign rx_bit = loopback ? o_tx_data : rxd_q[1];
	assign rx_strobe = rx_edge && (!framed || rx_fr_q == RX_DATA);

	always @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			rx_fr_q <= RX_IDLE;
			rx_bit_cnt_q <= 3'd0;
			rx_sync_forward_register <= 11'h0;
		end else begin
			if (rx_strobe) begin
				rx_sync_forward_register <= {rx_sync_forward_register[9:0], rx_bit};
			end
			if (!framed) begin
				rx_fr_q <= RX_IDLE;
			end else if (rx_edge) begin
				case (rx_fr_q)
					RX_IDLE: begin
						if (!rx_bit) begin
							rx_fr_q <= RX_DATA;
						end
						rx_bit_cnt_q <= 3'd0;
					end
					RX_DATA: begin
						rx_bit_cnt_q <= rx_bit_cnt_q + 3'd1;
						if (rx_bit_cnt_q == nbits_last) begin
							rx_fr_q <= RX_STOP;
						end
					end
					RX_STOP: rx_fr_q <= RX_IDLE;
					default: rx_fr_q <= RX_IDLE;
				endcase
			end
		end
	end

	// Feed-forward prediction; a constant-high input never matches, so it cannot sync.
	always @* begin
		case (pat_sel)
			`BPS_PAT_511: rx_pred = rx_sync_forward_register[`BPS_TAP511_A] ^
				rx_sync_forward_register[`BPS_TAP511_B];
			`BPS_PAT_2047: rx_pred = rx_sync_forward_register[`BPS_TAP2047_A] ^
				rx_sync_forward_register[`BPS_TAP2047_B];
			default: rx_pred = rx_sync_forward_register[`BPS_TAP63_A] ^
				rx_sync_forward_register[`BPS_TAP63_B];
		endcase
	end

	// ----------------------------------------------------------------
	// Synchronisation, feedback register and error detection
	// ----------------------------------------------------------------
	reg [4:0] match_cnt_q;
	reg locked_q;
	reg sync_latch_q;
	reg [4:0] win_cnt_q;
	reg [2:0] win_err_q;
	reg [4:0] run_cnt_q;
	reg run_bit_q;
	reg [7:0] err_cnt_q;
	reg [7:0] event_q;
	wire rx_fb;
	wire sync_evt;
	wire bit_err;

	assign sync_evt = rx_strobe && !locked_q && !fixed_mode && (rx_bit == rx_pred) &&
		(match_cnt_q == `BPS_SYNC_MATCH - 5'd1);
	assign bit_err = rx_strobe && locked_q && (rx_bit != rx_fb);

	bps_prbs u_rx_feedback_register (
		.i_clk_sys(i_clk_sys),
		.i_reset_n(i_reset_n),
		.i_step(rx_strobe && locked_q),
		.i_load(sync_evt),
		.i_load_val({rx_sync_forward_register[9:0], rx_bit}),
		.i_pat(pat_sel),
		.o_state_q(),
		.o_fb(rx_fb)
	);

	always @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			match_cnt_q <= 5'd0;
			locked_q <= 1'b0;
			sync_latch_q <= 1'b0;
			win_cnt_q <= 5'd0;
			win_err_q <= 3'd0;
		end else begin
			// A saturated match run would block the next sync, so a new pattern starts over.
			if (pat_change || fixed_mode) begin
				match_cnt_q <= 5'd0;
			end else if (rx_strobe) begin
				match_cnt_q <= (rx_bit != rx_pred) ? 5'd0 :
					(match_cnt_q == `BPS_SYNC_MATCH) ? match_cnt_q : match_cnt_q + 5'd1;
			end
			// Lock holds across single errors; only a dense burst in the window, a pattern change or fixed mode drops it.
			if (pat_change || fixed_mode) begin
				locked_q <= 1'b0;
			end else if (sync_evt) begin
				locked_q <= 1'b1;
			end else if (bit_err && win_err_q == `BPS_LOCK_ERR_MAX - 3'd1) begin
				locked_q <= 1'b0;
			end
			if (!locked_q || sync_evt) begin
				win_cnt_q <= 5'd0;
				win_err_q <= 3'd0;
			end else if (rx_strobe) begin
				win_cnt_q <= win_cnt_q + 5'd1;
				if (win_cnt_q == 5'h1f) begin
					win_err_q <= 3'd0;
				end else if (bit_err) begin
					win_err_q <= win_err_q + 3'd1;
				end
			end
			if (sync_evt) begin
				sync_latch_q <= 1'b1;
			end else if (clr_sync) begin
				sync_latch_q <= 1'b0;
			end
		end
	end

	always @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			run_cnt_q <= 5'd0;
			run_bit_q <= 1'b0;
			o_dropout <= 1'b0;
			o_cpu_test_input_lock <= 1'b1;
			o_cpu_counter_input_errors <= 1'b0;
			err_cnt_q <= 8'h00;
			event_q <= 8'h00;
		end else begin
			if (rx_strobe) begin
				run_bit_q <= rx_bit;
				if (rx_bit != run_bit_q) begin
					run_cnt_q <= 5'd0;
				end else if (run_cnt_q != `BPS_DROPOUT_BITS) begin
					run_cnt_q <= run_cnt_q + 5'd1;
				end
			end
			o_dropout <= (run_cnt_q == `BPS_DROPOUT_BITS);
			o_cpu_test_input_lock <= !locked_q;
			o_cpu_counter_input_errors <= bit_err;
			if (bit_err) begin
				err_cnt_q <= (err_cnt_q == 8'hff) ? err_cnt_q : err_cnt_q + 8'h01;
			end else if (clr_count) begin
				err_cnt_q <= 8'h00;
			end
			if (bit_err) begin
				event_q <= {event_q[6:0], 1'b1};
			end else if (clr_event) begin
				event_q <= 8'h00;
			end
		end
	end

	// ----------------------------------------------------------------
	// Register read port
	// ----------------------------------------------------------------
	wire [7:0] rx_word;
	wire [7:0] status;
	genvar gi;

	// The first bit sent lands deepest, so the word is reversed to read back as written.
	generate
		for (gi = 0; gi < 8; gi = gi + 1) begin : g_rx_word
			assign rx_word[gi] = rx_sync_forward_register[7 - gi];
		end
	endgenerate

	assign status = {4'h0, !locked_q, o_dropout, locked_q, sync_latch_q};

	always @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_rd_data <= 8'h00;
		end else if (!i_rd_en) begin
			o_rd_data <= 8'h00;
		end else begin
			case (i_addr)
				`BPS_REG_CTRL: o_rd_data <= ctrl_q;
				`BPS_REG_BITS: o_rd_data <= {4'h0, bits_sel_q};
				`BPS_REG_STATUS: o_rd_data <= status;
				`BPS_REG_TXWORD: o_rd_data <= tx_word_q;
				`BPS_REG_RXWORD: o_rd_data <= rx_word;
				`BPS_REG_ERRCNT: o_rd_data <= err_cnt_q;
				`BPS_REG_EVENT: o_rd_data <= event_q;
				default: o_rd_data <= 8'h00;
			endcase
		end
	end

endmodule

/* File: rtl/bps_defs.vh */
`ifndef BPS_DEFS_VH
`define BPS_DEFS_VH

// ----------------------------------------------------------------
// Pattern selection codes
// ----------------------------------------------------------------
`define BPS_PAT_2047 2'b00
`define BPS_PAT_511 2'b01
`define BPS_PAT_63 2'b10
`define BPS_PAT_HIGH 2'b11

// ----------------------------------------------------------------
// Feedback tap positions, newest bit at index 0
// ----------------------------------------------------------------
`define BPS_TAP63_A 5
`define BPS_TAP63_B 4
`define BPS_TAP511_A 8
`define BPS_TAP511_B 4
`define BPS_TAP2047_A 10
`define BPS_TAP2047_B 8
`define BPS_SEED 11'h7ff

// ----------------------------------------------------------------
// Data bit count select codes
// ----------------------------------------------------------------
`define BPS_SEL_5BITS 4'h5
`define BPS_SEL_6BITS 4'h6
`define BPS_SEL_7BITS 4'h7
`define BPS_SEL_8BITS 4'h8

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define BPS_REG_CTRL 4'h0
`define BPS_REG_BITS 4'h1
`define BPS_REG_CMD 4'h2
`define BPS_REG_STATUS 4'h3
`define BPS_REG_TXWORD 4'h4
`define BPS_REG_RXWORD 4'h5
`define BPS_REG_ERRCNT 4'h6
`define BPS_REG_EVENT 4'h7

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define BPS_CTRL_PAT_LO 0
`define BPS_CTRL_PAT_HI 1
`define BPS_CTRL_FIXED 2
`define BPS_CTRL_ERRGEN 3
`define BPS_CTRL_FRAMED 4
`define BPS_CTRL_LOOP 5
`define BPS_CMD_CLR_SYNC 0
`define BPS_CMD_CLR_EVENT 1
`define BPS_CMD_CLR_COUNT 2
`define BPS_ST_SYNC 0
`define BPS_ST_LOCKED 1
`define BPS_ST_DROPOUT 2
`define BPS_ST_LOCK_LOSS 3

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define BPS_CTRL_RST 8'h00
`define BPS_BITS_RST 4'h8
`define BPS_TXWORD_RST 8'h00

// ----------------------------------------------------------------
// Receiver thresholds and transmit error-injection count, in line bits or errors
// ----------------------------------------------------------------
`define BPS_SYNC_MATCH 5'd16
`define BPS_LOCK_ERR_MAX 3'd4
`define BPS_DROPOUT_BITS 5'd24
`define BPS_ERRGEN_LAST 4'hf

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define BPS_CLK_MHZ 100
`define BPS_LOAD_PULSE_NS 1300
`define BPS_LOAD_PULSE_CYC ((`BPS_LOAD_PULSE_NS * `BPS_CLK_MHZ + 999) / 1000)
`define BPS_LOAD_RATE_HZ 100
`define BPS_LOAD_PERIOD_CYC (`BPS_CLK_MHZ * 1000000 / `BPS_LOAD_RATE_HZ)

`endif

/* File: rtl/bps_prbs.v */
`timescale 1ns/1ps
`include "bps_defs.vh"

module bps_prbs (
	input wire i_clk_sys,
	input wire i_reset_n,
	input wire i_step,
	input wire i_load,
	input wire [10:0] i_load_val,
	input wire [1:0] i_pat,
	output reg [10:0] o_state_q,
	output reg o_fb
);

	// Feedback picks the stage pair of the selected length; the high pattern is a constant one.
	always @* begin
		case (i_pat)
			`BPS_PAT_63: o_fb = o_state_q[`BPS_TAP63_A] ^ o_state_q[`BPS_TAP63_B];
			`BPS_PAT_511: o_fb = o_state_q[`BPS_TAP511_A] ^ o_state_q[`BPS_TAP511_B];
			`BPS_PAT_2047: o_fb = o_state_q[`BPS_TAP2047_A] ^ o_state_q[`BPS_TAP2047_B];
			default: o_fb = 1'b1;
		endcase
	end

	always @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_state_q <= `BPS_SEED;
		end else if (i_load) begin
			o_state_q <= i_load_val;
		end else if (i_step) begin
			o_state_q <= {o_state_q[9:0], o_fb};
		end
	end

endmodule

/* File: sim/bps_core_assertions.sv */
`timescale 1ns/1ps
`include "bps_defs.vh"

module bps_core_chk #(
	parameter [19:0] LOAD_PERIOD_CYC = 20'd2000
) (
	input wire i_clk_sys,
	input wire i_reset_n,
	input wire [3:0] i_addr,
	input wire [7:0] i_wr_data,
	input wire i_wr_en,
	input wire i_rd_en,
	input wire [7:0] o_rd_data,
	input wire i_tx_data_clk,
	input wire o_tx_data,
	input wire o_tx_load_strobe,
	input wire o_cpu_test_input_lock,
	input wire o_cpu_counter_input_errors,
	input wire o_dropout
);
	reg [7:0] hi_q;
	reg [19:0] lo_q;
	reg seen_q;
	reg [7:0] ctrl_q;
	reg [3:0] bits_q;
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_reset_n);
	// ----------------------------------------------------------------
	// Shadow state
	// ----------------------------------------------------------------
	// The gap is only judged between two pulses of one fixed-word run.
	always @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			hi_q <= 8'h00;
			lo_q <= 20'h00000;
			seen_q <= 1'b0;
			ctrl_q <= `BPS_CTRL_RST;
			bits_q <= `BPS_BITS_RST;
		end else begin
			hi_q <= o_tx_load_strobe ? hi_q + 8'h01 : 8'h00;
			lo_q <= o_tx_load_strobe ? 20'h00000 : lo_q + 20'h00001;
			seen_q <= ctrl_q[`BPS_CTRL_FIXED] & (seen_q | o_tx_load_strobe);
			if (i_wr_en && i_addr == `BPS_REG_CTRL) begin
				ctrl_q <= i_wr_data;
			end
			if (i_wr_en && i_addr == `BPS_REG_BITS) begin
				bits_q <= i_wr_data[3:0];
			end
		end
	end
	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	property p_load_len;
		$fell(o_tx_load_strobe) |-> hi_q == 8'd130;
	endproperty
	a_load_len: assert property (p_load_len) else $error("load width");
	property p_load_gap;
		$rose(o_tx_load_strobe) && seen_q |-> lo_q == LOAD_PERIOD_CYC - 20'd130;
	endproperty
	a_load_gap: assert property (p_load_gap) else $error("load period");
	property p_load_mode;
		$rose(o_tx_load_strobe) |-> ctrl_q[`BPS_CTRL_FIXED];
	endproperty
	a_load_mode: assert property (p_load_mode) else $error("load outside mode");
	property p_err_pulse;
		o_cpu_counter_input_errors |=> !o_cpu_counter_input_errors;
	endproperty
	a_err_pulse: assert property (p_err_pulse) else $error("error pulse long");
	property p_rd_idle;
		!i_rd_en |=> o_rd_data == 8'h00;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data idle");
	property p_rd_none;
		i_rd_en && (i_addr > `BPS_REG_EVENT || i_addr == `BPS_REG_CMD) |=> o_rd_data == 8'h00;
	endproperty
	a_rd_none: assert property (p_rd_none) else $error("unmapped read");
	property p_bits_back;
		i_rd_en && i_addr == `BPS_REG_BITS |=> o_rd_data[3:0] == bits_q;
	endproperty
	a_bits_back: assert property (p_bits_back) else $error("bit select read");
	property p_st_lock;
		i_rd_en && i_addr == `BPS_REG_STATUS |=> o_rd_data[3] == o_cpu_test_input_lock;
	endproperty
	a_st_lock: assert property (p_st_lock) else $error("lock status");
	property p_st_drop;
		i_rd_en && i_addr == `BPS_REG_STATUS |=> o_rd_data[2] == $past(o_dropout);
	endproperty
	a_st_drop: assert property (p_st_drop) else $error("dropout status");
	property p_tx_edge;
		$changed(o_tx_data) |-> $past(i_tx_data_clk, 2) && !$past(i_tx_data_clk, 7);
	endproperty
	a_tx_edge: assert property (p_tx_edge) else $error("tx off edge");
endmodule

bind bps_core bps_core_chk #(.LOAD_PERIOD_CYC(LOAD_PERIOD_CYC)) i_bps_core_chk (
	.i_clk_sys,
	.i_reset_n,
	.i_addr,
	.i_wr_data,
	.i_wr_en,
	.i_rd_en,
	.o_rd_data,
	.i_tx_data_clk,
	.o_tx_data,
	.o_tx_load_strobe,
	.o_cpu_test_input_lock,
	.o_cpu_counter_input_errors,
	.o_dropout
);

/* File: sim/bps_core_tb.sv */
`timescale 1ns/1ps
`include "bps_defs.vh"
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin err_count++; $display("[FAIL] %s exp %h got %h", n, e, g); end end

module bps_core_tb;
	localparam [1:0] PC [0:2] = '{`BPS_PAT_2047, `BPS_PAT_511, `BPS_PAT_63};
	localparam int PA [0:2] = '{11, 9, 6};
	localparam int PB [0:2] = '{9, 5, 5};
	localparam [3:0] RA [0:7] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h7, 4'hf};
	reg clk, rst_n, wr_en, rd_en, h, ok;
	reg [3:0] addr;
	reg [7:0] wr_data, d;
	reg [15:0] hist;
	reg [63:0] fr;
	wire [7:0] rd_data;
	wire tx_clk, rx_clk, rx_data, tx_data, strobe, pbit, lock, err_p, drop;
	integer err_count, cmp_count, n_err, i, j, f, k, ta, tb;
	bps_core #(.LOAD_PERIOD_CYC(20'd2000)) i_bps_core (.i_clk_sys(clk), .i_reset_n(rst_n),
		.i_addr(addr), .i_wr_data(wr_data), .i_wr_en(wr_en), .i_rd_en(rd_en),
		.o_rd_data(rd_data), .i_tx_data_clk(tx_clk), .i_rx_data_clk(rx_clk),
		.i_rx_data(rx_data), .o_tx_data(tx_data), .o_tx_load_strobe(strobe),
		.o_tx_parallel_bit(pbit), .o_cpu_test_input_lock(lock),
		.o_cpu_counter_input_errors(err_p), .o_dropout(drop));
	bps_link_model i_bps_link_model (.i_tx_data(tx_data), .o_tx_clk(tx_clk),
		.o_rx_clk(rx_clk), .o_rx_data(rx_data));
	// ----------------------------------------------------------------
	// Access tasks
	// ----------------------------------------------------------------
	task wr(input [3:0] a, input [7:0] v);
		@(posedge clk);
		addr <= a;
		wr_data <= v;
		wr_en <= 1'b1;
		@(posedge clk);
		wr_en <= 1'b0;
	endtask
	task rd(input [3:0] a);
		@(posedge clk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clk);
		rd_en <= 1'b0;
		#1;
		d = rd_data;
	endtask
	// Line bits are taken well after each edge, once the output has moved.
	task bits(input integer n);
		repeat (n) begin
			@(posedge tx_clk);
			repeat (8) @(posedge clk);
			hist = {hist[14:0], tx_data};
			fr = {fr[62:0], tx_data};
			k = k + 1;
			if (ta != 0 && k > 24) `CHK("prbs", hist[ta] ^ hist[tb], hist[0])
		end
	endtask
	task wrap_up;
		if (err_count == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) if (err_p === 1'b1) n_err <= n_err + 1;
	initial begin
		repeat (100000) @(posedge clk);
		err_count++;
		wrap_up;
	end
	initial begin
		{rst_n, wr_en, rd_en, addr, wr_data} = 0;
		{err_count, cmp_count, n_err, ta, tb, k, hist, fr} = 0;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		for (i = 0; i < 8; i++) begin
			rd(RA[i]);
			`CHK("reset", (i == 1) ? 8'h08 : (i == 3) ? 8'h08 : 8'h00, d & ((i == 3) ? 8'h0f : 8'hff))
		end
		for (i = 0; i < 3; i++) begin
			wr(`BPS_REG_CTRL, {6'h00, PC[i]});
			rd(`BPS_REG_STATUS);
			`CHK("sync clr", 1'b0, d[0])
			ta = PA[i];
			tb = PB[i];
			k = 0;
			bits(96);
			rd(`BPS_REG_STATUS);
			`CHK("sync", 8'h03, d & 8'h0f)
		end
		ta = 0;
		wr(`BPS_REG_CMD, 8'h01);
		bits(64);
		rd(`BPS_REG_STATUS);
		`CHK("once", 8'h02, d & 8'h0f)
		wr(`BPS_REG_CTRL, {6'h00, `BPS_PAT_HIGH});
		bits(40);
		rd(`BPS_REG_STATUS);
		`CHK("high st", 8'h0c, d & 8'h0e)
		`CHK("high pins", 2'b11, {lock, drop})
		wr(`BPS_REG_CTRL, 8'h02);
		bits(64);
		rd(`BPS_REG_STATUS);
		`CHK("prbs st", 8'h02, d & 8'h0e)
		`CHK("prbs pins", 2'b00, {lock, drop})
		wr(`BPS_REG_CMD, 8'h06);
		rd(`BPS_REG_EVENT);
		`CHK("event clr", 8'h00, d)
		n_err = 0;
		wr(`BPS_REG_CTRL, 8'h0a);
		bits(128);
		wr(`BPS_REG_CTRL, 8'h02);
		bits(8);
		`CHK("pulses", 32'd8, n_err)
		rd(`BPS_REG_ERRCNT);
		`CHK("count", 8'h08, d)
		rd(`BPS_REG_EVENT);
		`CHK("event", 8'hff, d)
		for (i = 5; i < 9; i++) begin
			wr(`BPS_REG_CTRL, 8'h03);
			wr(`BPS_REG_BITS, i[7:0]);
			rd(`BPS_REG_BITS);
			`CHK("sel", i[3:0], d[3:0])
			wr(`BPS_REG_CTRL, 8'h32);
			bits(80);
			rd(`BPS_REG_STATUS);
			`CHK("fr sync", 1'b1, d[0])
			h = 1'b0;
			for (j = 0; j < i + 2; j++) begin
				ok = 1'b1;
				for (f = 0; f < 4; f++)
					ok = ok & fr[j + f * (i + 2)] & ~fr[j + f * (i + 2) + i + 1];
				h = h | ok;
			end
			`CHK("frame", 1'b1, h)
		end
		wr(`BPS_REG_TXWORD, 8'h5a);
		wr(`BPS_REG_CTRL, 8'h14);
		for (j = 0; j < 3000 && strobe !== 1'b1; j++) @(posedge clk);
		`CHK("strobe", 2'b10, {strobe, pbit})
		// The word stands in the receiver only until the next data bit, so poll for it.
		d = 8'h00;
		for (j = 0; j < 1000 && d !== 8'h5a; j++)
			rd(`BPS_REG_RXWORD);
		`CHK("word", 8'h5a, d)
		for (j = 0; j < 4000 && strobe !== 1'b1; j++) @(posedge clk);
		for (j = 0; j < 4000 && strobe === 1'b1; j++) @(posedge clk);
		`CHK("load width", `BPS_LOAD_PULSE_CYC, j)
		for (j = 0; j < 4000 && strobe !== 1'b1; j++) @(posedge clk);
		`CHK("load gap", 2000 - `BPS_LOAD_PULSE_CYC, j)
		wrap_up;
	end
endmodule

/* File: sim/bps_link_model.sv */
`timescale 1ns/1ps

module bps_link_model (
	input wire i_tx_data,
	output reg o_tx_clk,
	output wire o_rx_clk,
	output reg o_rx_data
);
	// Odd start offset keeps the data clock out of step with the system clock.
	initial begin
		o_tx_clk = 1'b0;
		o_rx_data = 1'b1;
		#3.3;
		forever #80 o_tx_clk = ~o_tx_clk;
	end
	assign o_rx_clk = o_tx_clk;
	// Relaunched mid-bit, so the receiver's rising edge sees a settled level.
	always @(negedge o_tx_clk) o_rx_data <= i_tx_data;
endmodule
